// File: src/hpl_defs.svh
// Offsets-free constant set for the hub port indicator block: strap, reset and toggle timing.
// Assumes a single core clock whose period is given below in picoseconds.
`ifndef HPL_DEFS_SVH
`define HPL_DEFS_SVH

// Core clock period, 40 MHz
`define HPL_CLK_PERIOD_PS    25000
// Least strap hold after reset release, in picoseconds (16.7 ns)
`define HPL_STRAP_HOLD_PS    16700
// Strap hold in cycles, rounded up, never below one
`define HPL_STRAP_HOLD_CYC   ((`HPL_STRAP_HOLD_PS + `HPL_CLK_PERIOD_PS - 1) / `HPL_CLK_PERIOD_PS)
// Longest time from reset release to inactive outputs, in nanoseconds (2.0 us)
`define HPL_INACTIVE_MAX_NS  2000
// Same bound in cycles, rounded down
`define HPL_INACTIVE_MAX_CYC ((`HPL_INACTIVE_MAX_NS * 1000) / `HPL_CLK_PERIOD_PS)
// Half period of the 1 kHz toggle, in nanoseconds
`define HPL_TOGGLE_HALF_NS   500000
// Half period in cycles
`define HPL_TOGGLE_HALF_CYC  ((`HPL_TOGGLE_HALF_NS * 1000) / `HPL_CLK_PERIOD_PS)
// Number of downstream ports
`define HPL_PORTS            4
// Width of the strap phase counter
`define HPL_PHASE_CNT_W      8

`endif

// File: src/hpl_pkg.sv
// Types shared by the hub port indicator block.
// Assumes hpl_defs.svh is on the include path.
`include "hpl_defs.svh"

package hpl_pkg;

    // Indicator modes, exactly three
    typedef enum logic [1:0] {
        HPL_MODE_USB,
        HPL_MODE_OWNER,
        HPL_MODE_DUAL
    } hpl_mode_t;

    // Upstream owner of a downstream port
    typedef enum logic [1:0] {
        HPL_OWNER_NONE,
        HPL_OWNER_A,
        HPL_OWNER_B
    } hpl_owner_t;

    // Start-up phases of the indicator driver
    typedef enum logic [1:0] {
        HPL_PH_STRAP,
        HPL_PH_WAIT_CFG,
        HPL_PH_RUN
    } hpl_phase_t;

    // Per-port status delivered by the hub core
    typedef struct packed {
        logic       enabled;
        logic       connected;
        logic       highSpeed;
        hpl_owner_t owner;
    } hpl_port_status_t;

    // One indicator pin as driven: level and active-low enable
    typedef struct packed {
        logic level;
        logic oeN;
    } hpl_pin_t;

endpackage : hpl_pkg

// File: src/hpl_tick_div.sv
// Square wave divider: inverts its output every HALF_CYCLES clocks while enabled.
// Assumes one clock domain; output parks low when disabled.
`timescale 1ns/1ps
`default_nettype none

module hpl_tick_div
    import hpl_pkg::*;
#(
    parameter int HALF_CYCLES = 20000
)(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic enable,
    output logic      wave
);

    localparam int CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;

    typedef struct packed {
        logic [CW-1:0] count;
        logic          wave;
    } hpl_div_state_t;

    hpl_div_state_t st;
    hpl_div_state_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // Count and invert; restarting on disable keeps the first half period full
    always_comb
    begin
        next_st = st;
        if (!enable)
        begin
            next_st.count = '0;
            next_st.wave  = 1'b0;
        end
        else if (st.count == CW'(HALF_CYCLES - 1))
        begin
            next_st.count = '0;
            next_st.wave  = ~st.wave;
        end
        else
        begin
            next_st.count = st.count + CW'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign wave = st.wave;

endmodule : hpl_tick_div

`default_nettype wire

// File: src/hub_port_led_indicator.sv
// Downstream port indicator driver for a two-host, four-port switching hub.
// Assumes status inputs are synchronous to ref_clk and the pads resolve level/enable pairs.
// Assumes a strap resistor on every first pin and one config strobe per reset.
//
// Behaviour
// - USB mode: first pin is port green, second pin is port amber.
// - USB mode shows nothing about upstream host ownership.
// - Basic ownership: first pin asserted for host A, second for host B.
// - Ownership modes: disabled or unassigned port leaves both pins off.
// - Ownership indication works with absent owner host, and in suspend for all but unattached dual-mode ports.
// - Dual mode: owner pin low for low or full speed device.
// - Dual mode: owner pin high for high speed device.
// - Dual mode: owner pin toggles at 1 kHz with nothing attached.
// - Dual mode: off is high impedance; non-owner pin stays released.
// - In suspend a connected port keeps its enumerated speed level.
// - Dual mode: hub suspend releases unattached assigned pins; toggle suppressed throughout.
// - All indicator outputs disabled while reset is asserted.
// - Outputs driven inactive within 2.0 us after reset release.
// - Exactly three modes, only one active at a time.
// - First pins sampled as straps; high means active-low, low active-high.
//
// Start-up:
//   reset        all pins released, configuration forgotten
//   first edge   straps taken, all pins driven inactive
//   then         one config strobe awaited; later ones ignored
//   running      pins follow status inputs one cycle later
//
// Limitations:
//   - second pins are never sampled; both pins of a port share a strap
//   - an unknown mode code runs as USB mode
//   - owner codes other than host A or B count as unassigned
//   - hub suspend stops the toggle for every port
//   - enumerated speed is refreshed only while the hub is awake
`timescale 1ns/1ps
`default_nettype none

`include "hpl_defs.svh"

module hub_port_led_indicator
    import hpl_pkg::*;
#(
    parameter int NPORTS      = `HPL_PORTS,
    parameter int TOGGLE_HALF = `HPL_TOGGLE_HALF_CYC
)(
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst,

    // Configuration strobe and code
    input  wire logic                          configLoad,
    input  wire hpl_mode_t                     configMode,

    // Hub core status, all levels
    input  wire logic                          hubSuspend,
    input  wire hpl_port_status_t [NPORTS-1:0] portStatus,
    input  wire logic [NPORTS-1:0]             usbGreen,
    input  wire logic [NPORTS-1:0]             usbAmber,

    // Pad readback; only the first pins are read, as straps
    input  wire logic [NPORTS-1:0]             portIndicatorFirstNIn,
    input  wire logic [NPORTS-1:0]             portIndicatorSecondNIn,

    // Pad drive: level and active-low enable per pin
    output logic [NPORTS-1:0]                  portIndicatorFirstNOut,
    output logic [NPORTS-1:0]                  portIndicatorFirstNOeN,
    output logic [NPORTS-1:0]                  portIndicatorSecondNOut,
    output logic [NPORTS-1:0]                  portIndicatorSecondNOeN,

    // Latched configuration for the rest of the hub
    output hpl_mode_t                          activeMode,
    output logic                               modeValid,
    output logic [NPORTS-1:0]                  strapActiveLow
);

    localparam int PCW = `HPL_PHASE_CNT_W;

    // Whole state of the driver
    typedef struct packed {
        // Sequencing
        hpl_phase_t              phase;
        logic [PCW-1:0]          phaseCount;

        // Latched configuration
        hpl_mode_t               mode;
        logic                    modeValid;
        logic [NPORTS-1:0]       activeLow;

        // Speed kept across suspend
        logic [NPORTS-1:0]       speedHeld;

        // Registered pad drive
        logic [NPORTS-1:0]       firstOut;
        logic [NPORTS-1:0]       firstOeN;
        logic [NPORTS-1:0]       secondOut;
        logic [NPORTS-1:0]       secondOeN;
    } hpl_top_state_t;

    hpl_top_state_t st;
    hpl_top_state_t next_st;
    logic           toggleWave;
    logic           toggleEnable;

    ////////////////////////////////////////////////////////////////////////////
    // 1 kHz source; held off during suspend so no edge leaks out
    // The divider restarts from low when disabled, so the first
    // visible half period after suspend is always a full one
    assign toggleEnable = (st.phase == HPL_PH_RUN) && (st.mode == HPL_MODE_DUAL) && !hubSuspend;

    hpl_tick_div #(
        .HALF_CYCLES (TOGGLE_HALF)
    ) u_toggle (
        .ref_clk (ref_clk),
        .rst     (rst),
        .enable  (toggleEnable),
        .wave    (toggleWave)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Single-colour drive: asserted or inactive level per strapped polarity
    // XOR with the strap fits either LED wiring
    function automatic hpl_pin_t drive_mono(input logic asserted, input logic actLow);
        hpl_pin_t p;
        p.level = asserted ^ actLow;
        p.oeN   = 1'b0;
        return p;
    endfunction : drive_mono

    // Dual-colour drive for the owning host's pin
    // Connected: steady speed level. Unattached: toggle, or off in suspend.
    // Off is a released pad, so both LEDs of the pair stay dark.
    function automatic hpl_pin_t drive_dual(input hpl_port_status_t s, input logic speed,
                                            input logic suspended, input logic wave);
        hpl_pin_t p;
        p.level = 1'b0;
        p.oeN   = 1'b1;
        if (s.connected)
        begin
            p.level = speed;
            p.oeN   = 1'b0;
        end
        else if (!suspended)
        begin
            p.level = wave;
            p.oeN   = 1'b0;
        end
        return p;
    endfunction : drive_dual

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: strap capture, wait for configuration, then drive pins
    // Pin drive per port in each mode (first pin / second pin):
    //   USB    green request / amber request, both driven
    //   OWNER  owned by host A / owned by host B, both driven
    //   DUAL   owner pin: speed level, toggle or off; other pin off
    // Disabled or unassigned ports show nothing in ownership modes.
    // Drive values are registered so pads move only on a clock edge.
    always_comb
    begin
        // Scratch values, all set before use
        hpl_pin_t pa;
        hpl_pin_t pb;
        logic     ownA;
        logic     ownB;
        logic     live;
        pa      = '0;
        pb      = '0;
        ownA    = 1'b0;
        ownB    = 1'b0;
        live    = 1'b0;
        next_st = st;

        case (st.phase)
            HPL_PH_STRAP:
            begin
                // Pins stay released so the strap resistors set the level
                // One cycle covers the strap hold time at this clock;
                // the counter freezes once this phase is left
                next_st.phaseCount = st.phaseCount + PCW'(1);
                if (st.phaseCount == PCW'(`HPL_STRAP_HOLD_CYC - 1))
                begin
                    next_st.activeLow = portIndicatorFirstNIn;
                    next_st.phase     = HPL_PH_WAIT_CFG;
                    // Inactive level is the inverse of the active one
                    for (int i = 0; i < NPORTS; i++)
                    begin
                        next_st.firstOut[i]  = portIndicatorFirstNIn[i];
                        next_st.secondOut[i] = portIndicatorFirstNIn[i];
                    end
                    next_st.firstOeN  = '0;
                    next_st.secondOeN = '0;
                end
            end

            HPL_PH_WAIT_CFG:
            begin
                // Pins keep the inactive level while the load is pending;
                // a strobe sent before this phase is lost
                if (configLoad)
                begin
                    // Unknown codes fall back to USB mode so one mode is always active
                    case (configMode)
                        HPL_MODE_OWNER: next_st.mode = HPL_MODE_OWNER;
                        HPL_MODE_DUAL:  next_st.mode = HPL_MODE_DUAL;
                        default:        next_st.mode = HPL_MODE_USB;
                    endcase
                    next_st.modeValid = 1'b1;
                    next_st.phase     = HPL_PH_RUN;
                end
            end

            HPL_PH_RUN:
            begin
                // Mode is frozen here; further configLoad pulses are ignored
                for (int i = 0; i < NPORTS; i++)
                begin
                    // Owner codes other than A or B light neither pin
                    ownA = portStatus[i].owner == HPL_OWNER_A;
                    ownB = portStatus[i].owner == HPL_OWNER_B;
                    live = portStatus[i].enabled;
                    // Speed only tracks while awake, so suspend keeps the enumerated one
                    if (portStatus[i].connected && !hubSuspend)
                        next_st.speedHeld[i] = portStatus[i].highSpeed;

                    case (st.mode)
                        HPL_MODE_USB:
                        begin
                            // Green and amber follow the core
                            pa = drive_mono(usbGreen[i], st.activeLow[i]);
                            pb = drive_mono(usbAmber[i], st.activeLow[i]);
                        end
                        HPL_MODE_OWNER:
                        begin
                            // No suspend or host-presence term: ownership always shown
                            pa = drive_mono(live && ownA, st.activeLow[i]);
                            pb = drive_mono(live && ownB, st.activeLow[i]);
                        end
                        HPL_MODE_DUAL:
                        begin
                            // Start off; only the owner pin may drive
                            pa = '{level: 1'b0, oeN: 1'b1};
                            pb = '{level: 1'b0, oeN: 1'b1};
                            if (live && ownA)
                                pa = drive_dual(portStatus[i], next_st.speedHeld[i], hubSuspend, toggleWave);
                            else if (live && ownB)
                                pb = drive_dual(portStatus[i], next_st.speedHeld[i], hubSuspend, toggleWave);
                        end
                        default:
                        begin
                            // Not reachable; release as a safe state
                            pa = '{level: 1'b0, oeN: 1'b1};
                            pb = '{level: 1'b0, oeN: 1'b1};
                        end
                    endcase

                    next_st.firstOut[i]  = pa.level;
                    next_st.firstOeN[i]  = pa.oeN;
                    next_st.secondOut[i] = pb.level;
                    next_st.secondOeN[i] = pb.oeN;
                end
            end

            default:
            begin
                next_st.phase = HPL_PH_STRAP;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; reset releases every pin (enables high)
    // Reset needs no clock, so the pads let go at once and the
    // straps read cleanly on the first edge after release
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st           <= '0;
            st.phase     <= HPL_PH_STRAP;
            st.mode      <= HPL_MODE_USB;
            st.firstOeN  <= '1;
            st.secondOeN <= '1;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    // No logic between flip-flops and pads, so pins cannot glitch
    // from decode hazards
    assign portIndicatorFirstNOut  = st.firstOut;
    assign portIndicatorFirstNOeN  = st.firstOeN;
    assign portIndicatorSecondNOut = st.secondOut;
    assign portIndicatorSecondNOeN = st.secondOeN;
    assign activeMode              = st.mode;
    assign modeValid               = st.modeValid;
    assign strapActiveLow          = st.activeLow;

endmodule : hub_port_led_indicator

`default_nettype wire

// File: testbench/hpl_led_pins.sv
// Pad and LED model for the eight indicator pins, with strap resistors on every pin.
// Assumes level and active-low enable pairs from the driver.
`timescale 1ns/1ps
`default_nettype none

module hpl_led_pins #(
    parameter logic [3:0] STRAP = 4'h5
)(
    input  wire logic [3:0] firstOut,
    input  wire logic [3:0] firstOeN,
    input  wire logic [3:0] secondOut,
    input  wire logic [3:0] secondOeN,
    output logic [3:0]      firstIn,
    output logic [3:0]      secondIn
);
    // A released pin sits at its strap resistor level, never at the last driven value
    assign firstIn  = (firstOut & ~firstOeN) | (STRAP & firstOeN);
    assign secondIn = (secondOut & ~secondOeN) | (STRAP & secondOeN);
endmodule : hpl_led_pins

`default_nettype wire

// File: testbench/hpl_led_asserts.sv
// Concurrent checks on the port indicator driver, attached by bind.
// Assumes only the top module's ports; one clock, rst active high.
`timescale 1ns/1ps
`default_nettype none

module hpl_led_asserts
    import hpl_pkg::*;
#(
    parameter int NPORTS      = 4,
    parameter int TOGGLE_HALF = 8
)(
    input wire logic                          ref_clk,
    input wire logic                          rst,
    input wire logic                          configLoad,
    input wire hpl_mode_t                     configMode,
    input wire logic                          hubSuspend,
    input wire hpl_port_status_t [NPORTS-1:0] portStatus,
    input wire logic [NPORTS-1:0]             usbGreen,
    input wire logic [NPORTS-1:0]             usbAmber,
    input wire logic [NPORTS-1:0]             portIndicatorFirstNOut,
    input wire logic [NPORTS-1:0]             portIndicatorFirstNOeN,
    input wire logic [NPORTS-1:0]             portIndicatorSecondNOut,
    input wire logic [NPORTS-1:0]             portIndicatorSecondNOeN,
    input wire hpl_mode_t                     activeMode,
    input wire logic                          modeValid,
    input wire logic [NPORTS-1:0]             strapActiveLow
);
    ////////////////////////////////////////////////////////////////////////////////
    // Expected owner pin use per port; toggling pins are left out of the level check
    logic [NPORTS-1:0] ownA, ownB, oeA, oeB, lvA, lvB, hs;
    always_comb
    begin
        for (int i = 0; i < NPORTS; i++)
        begin
            ownA[i] = portStatus[i].enabled && (portStatus[i].owner == HPL_OWNER_A);
            ownB[i] = portStatus[i].enabled && (portStatus[i].owner == HPL_OWNER_B);
            oeA[i]  = !(ownA[i] && (portStatus[i].connected || !hubSuspend));
            oeB[i]  = !(ownB[i] && (portStatus[i].connected || !hubSuspend));
            lvA[i]  = ownA[i] && portStatus[i].connected && !hubSuspend;
            lvB[i]  = ownB[i] && portStatus[i].connected && !hubSuspend;
            hs[i]   = portStatus[i].highSpeed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_release;
        $fell(rst);
    endsequence
    sequence s_inactive;
        (portIndicatorFirstNOeN == '0) && (portIndicatorSecondNOeN == '0)
            && (portIndicatorFirstNOut == strapActiveLow);
    endsequence

    a_strap_window: assert property (s_release |->
        (portIndicatorFirstNOeN == '1) && (portIndicatorSecondNOeN == '1))
        else $error("pins driven in strap window");
    a_inactive_drive: assert property (s_release |-> ##[1:79] s_inactive)
        else $error("pins not inactive in time");
    a_mode_latch: assert property ($rose(modeValid) |-> $past(configLoad) && activeMode ==
        (($past(configMode) == 2'h3) ? HPL_MODE_USB : $past(configMode)))
        else $error("mode not latched from config");
    a_mode_held: assert property (modeValid |=> modeValid && $stable(activeMode))
        else $error("latched mode changed");
    a_mode_legal: assert property (activeMode != 2'h3)
        else $error("illegal mode");
    a_usb_map: assert property (modeValid && activeMode == HPL_MODE_USB |=>
        portIndicatorFirstNOut == ($past(usbGreen) ^ strapActiveLow)
        && portIndicatorSecondNOut == ($past(usbAmber) ^ strapActiveLow)
        && portIndicatorFirstNOeN == '0 && portIndicatorSecondNOeN == '0)
        else $error("usb mode pins wrong");
    a_owner_map: assert property (modeValid && activeMode == HPL_MODE_OWNER |=>
        portIndicatorFirstNOut == ($past(ownA) ^ strapActiveLow)
        && portIndicatorSecondNOut == ($past(ownB) ^ strapActiveLow)
        && portIndicatorFirstNOeN == '0 && portIndicatorSecondNOeN == '0)
        else $error("owner mode pins wrong");
    a_dual_release: assert property (modeValid && activeMode == HPL_MODE_DUAL |=>
        portIndicatorFirstNOeN == $past(oeA) && portIndicatorSecondNOeN == $past(oeB))
        else $error("dual mode enables wrong");
    a_dual_speed: assert property (modeValid && activeMode == HPL_MODE_DUAL |=>
        (((portIndicatorFirstNOut ^ $past(hs)) & $past(lvA)) == '0)
        && (((portIndicatorSecondNOut ^ $past(hs)) & $past(lvB)) == '0))
        else $error("dual mode speed level wrong");
endmodule : hpl_led_asserts

bind hub_port_led_indicator hpl_led_asserts #(.NPORTS(NPORTS), .TOGGLE_HALF(TOGGLE_HALF)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .configLoad(configLoad), .configMode(configMode), .hubSuspend(hubSuspend),
    .portStatus(portStatus), .usbGreen(usbGreen), .usbAmber(usbAmber),
    .portIndicatorFirstNOut(portIndicatorFirstNOut), .portIndicatorFirstNOeN(portIndicatorFirstNOeN),
    .portIndicatorSecondNOut(portIndicatorSecondNOut), .portIndicatorSecondNOeN(portIndicatorSecondNOeN),
    .activeMode(activeMode), .modeValid(modeValid), .strapActiveLow(strapActiveLow));

`default_nettype wire

// File: testbench/hub_port_led_indicator_bench.sv
// Self-checking bench for the port indicator driver, one reset and two config loads per run, USB mode run twice.
// Assumes the pad model feeds strap levels back; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none

module hub_port_led_indicator_bench
    import hpl_pkg::*;
;
    logic                   ref_clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   configLoad = 1'b0;
    logic                   hubSuspend = 1'b0;
    hpl_mode_t              configMode = HPL_MODE_USB;
    hpl_port_status_t [3:0] portStatus = '0;
    logic [3:0]             usbGreen = '0;
    logic [3:0]             usbAmber = '0;
    logic [3:0]             firstIn, secondIn, firstOut, firstOeN, secondOut, secondOeN, strapLow;
    hpl_mode_t              activeMode;
    logic                   modeValid;
    logic                   prev;
    int                     error_cnt = 0;
    int                     num_checks = 0;
    int                     n;

    always #12.5 ref_clk = ~ref_clk;

    hub_port_led_indicator #(.NPORTS(4), .TOGGLE_HALF(8)) DUT (
        .ref_clk(ref_clk), .rst(rst), .configLoad(configLoad), .configMode(configMode), .hubSuspend(hubSuspend),
        .portStatus(portStatus), .usbGreen(usbGreen), .usbAmber(usbAmber),
        .portIndicatorFirstNIn(firstIn), .portIndicatorSecondNIn(secondIn),
        .portIndicatorFirstNOut(firstOut), .portIndicatorFirstNOeN(firstOeN),
        .portIndicatorSecondNOut(secondOut), .portIndicatorSecondNOeN(secondOeN),
        .activeMode(activeMode), .modeValid(modeValid), .strapActiveLow(strapLow));

    hpl_led_pins #(.STRAP(4'h5)) u_pins (.firstOut(firstOut), .firstOeN(firstOeN), .secondOut(secondOut),
        .secondOeN(secondOeN), .firstIn(firstIn), .secondIn(secondIn));

    ////////////////////////////////////////////////////////////////////////////////
    // Shared compare, status packing and sequencing tasks
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function hpl_port_status_t st(input logic en, input logic c, input logic h, input hpl_owner_t o);
        return '{en, c, h, o};
    endfunction : st

    task tick(input int k);
        repeat (k) @(negedge ref_clk);
    endtask : tick

    task load(input hpl_mode_t m);
        configMode = m;
        configLoad = 1'b1;
        tick(1);
        configLoad = 1'b0;
        tick(1);
    endtask : load

    // Second load must be ignored, so the mode stays the first one; code 3 runs as USB
    task start(input hpl_mode_t m, input hpl_mode_t other);
        rst = 1'b1;
        usbGreen = '0;
        usbAmber = '0;
        portStatus = '0;
        hubSuspend = 1'b0;
        tick(16);
        check("oeN in reset", 8'({firstOeN, secondOeN}), 8'hff);
        rst = 1'b0;
        tick(4);
        check("inactive out", 8'({firstOut, secondOut}), 8'h55);
        check("inactive oeN", 8'({firstOeN, secondOeN}), 8'h00);
        check("straps", 8'(strapLow), 8'h05);
        load(m);
        load(other);
        check("mode", 8'(activeMode), 8'((m == hpl_mode_t'(2'h3)) ? HPL_MODE_USB : m));
        check("valid", 8'(modeValid), 8'h01);
    endtask : start

    task stop_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: USB, ownership, then dual-colour mode
    initial
    begin
        for (int k = 0; k < 2; k++)
        begin
            // Unknown code 3 first, then plain USB code after a fresh reset
            start(k ? HPL_MODE_USB : hpl_mode_t'(2'h3), HPL_MODE_DUAL);
            usbGreen = 4'h3;
            usbAmber = 4'h6;
            portStatus = k ? {4{st(1'b1, 1'b1, 1'b1, HPL_OWNER_B)}} : '0;
            tick(2);
            check("usb first", 8'(firstOut), 8'h06);
            check("usb second", 8'(secondOut), 8'h03);
        end
        start(HPL_MODE_OWNER, HPL_MODE_USB);
        portStatus = {st(1'b1, 1'b1, 1'b0, HPL_OWNER_NONE), st(1'b0, 1'b1, 1'b0, HPL_OWNER_A),
                      st(1'b1, 1'b0, 1'b0, HPL_OWNER_B), st(1'b1, 1'b0, 1'b0, HPL_OWNER_A)};
        for (int k = 0; k < 2; k++)
        begin
            hubSuspend = 1'(k);
            tick(2);
            check("owner first", 8'(firstOut), 8'h04);
            check("owner second", 8'(secondOut), 8'h07);
        end
        start(HPL_MODE_DUAL, HPL_MODE_OWNER);
        portStatus = {st(1'b0, 1'b1, 1'b1, HPL_OWNER_A), st(1'b1, 1'b0, 1'b0, HPL_OWNER_A),
                      st(1'b1, 1'b1, 1'b0, HPL_OWNER_B), st(1'b1, 1'b1, 1'b1, HPL_OWNER_A)};
        tick(2);
        check("dual first oeN", 8'(firstOeN), 8'h0a);
        check("dual second oeN", 8'(secondOeN), 8'h0d);
        check("dual high speed", 8'(firstOut[0]), 8'h01);
        check("dual full speed", 8'(secondOut[1]), 8'h00);
        // Sync to one toggle edge, then count cycles to the next
        for (int k = 0; k < 2; k++)
        begin
            prev = firstOut[2];
            n = 0;
            while (firstOut[2] === prev && n < 40)
            begin
                tick(1);
                n++;
            end
        end
        check("toggle half period", 8'(n), 8'h08);
        hubSuspend = 1'b1;
        portStatus[0].highSpeed = 1'b0;
        tick(2);
        check("suspend oeN", 8'(firstOeN), 8'h0e);
        check("suspend speed", 8'(firstOut[0]), 8'h01);
        stop_test();
    end
endmodule : hub_port_led_indicator_bench

`default_nettype wire
